/* File: hdl/psm_regs.svh */
// constants of the parameter store and maintenance command block
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH
// maintenance command ids
`define PSM_ID_ALARM_RESET      16'h00c0
`define PSM_ID_ALARM_HIST_CLR   16'h00c2
`define PSM_ID_POS_PRESET       16'h00c5
`define PSM_ID_CONFIGURE        16'h00c6
`define PSM_ID_INIT_KEEP_COMM   16'h00c7
`define PSM_ID_NV_READ          16'h00c8
`define PSM_ID_NV_WRITE         16'h00c9
`define PSM_ID_INIT_ALL         16'h00ca
`define PSM_ID_BACKUP_READ      16'h00cb
`define PSM_ID_BACKUP_WRITE     16'h00cc
`define PSM_ID_LATCH_CLR        16'h00cd
`define PSM_ID_SEQ_HIST_CLR     16'h00ce
`define PSM_ID_TRIP_CLR         16'h00cf
`define PSM_ID_TORQUE_OFF_REL   16'h00d0
`define PSM_ID_ZERO_PRESET      16'h00d1
`define PSM_ID_ZERO_PRESET_CLR  16'h00d2
`define PSM_ID_INFO_CLR         16'h00d3
`define PSM_ID_INFO_HIST_CLR    16'h00d4
`define PSM_ID_HIST_SEL         16'h00d5
// selector range and reset value
`define PSM_HIST_SEL_MAX        32'h0000000a
`define PSM_HIST_SEL_RST        32'h00000000
// parameter word reset value
`define PSM_WORD_RST            32'h00000000
`endif

/* File: hdl/psm_pkg.sv */
// types of the parameter store and maintenance command block
package psm_pkg;
    typedef enum logic [1:0] {
        PSM_CLASS_A,
        PSM_CLASS_B,
        PSM_CLASS_C,
        PSM_CLASS_D
    } psm_class_e;

    typedef enum logic [2:0] {
        PSM_BOOT,
        PSM_IDLE,
        PSM_COPY,
        PSM_WAIT_DROP
    } psm_state_e;

    typedef enum logic [2:0] {
        PSM_COPY_NV_TO_RAM,
        PSM_COPY_RAM_TO_NV,
        PSM_COPY_BK_TO_RAM,
        PSM_COPY_RAM_TO_BK,
        PSM_COPY_INIT_KEEP,
        PSM_COPY_INIT_ALL
    } psm_copy_e;
endpackage

/* File: hdl/psm_cmd_decode.sv */
// decoder from parameter id to one-hot maintenance action
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"
module psm_cmd_decode
(
    input  wire logic [15:0] id_i,
    output logic      [17:0] act_o,
    output logic             is_maint_o
);
    // --------------------------------------------------------------
    // one bit per action id 192 to 212, 193 and 195/196 have none
    // --------------------------------------------------------------
    always_comb
    begin
        act_o = '0;
        act_o[0]  = (id_i == `PSM_ID_ALARM_RESET);
        act_o[1]  = (id_i == `PSM_ID_ALARM_HIST_CLR);
        act_o[2]  = (id_i == `PSM_ID_POS_PRESET);
        act_o[3]  = (id_i == `PSM_ID_CONFIGURE);
        act_o[4]  = (id_i == `PSM_ID_INIT_KEEP_COMM);
        act_o[5]  = (id_i == `PSM_ID_NV_READ);
        act_o[6]  = (id_i == `PSM_ID_NV_WRITE);
        act_o[7]  = (id_i == `PSM_ID_INIT_ALL);
        act_o[8]  = (id_i == `PSM_ID_BACKUP_READ);
        act_o[9]  = (id_i == `PSM_ID_BACKUP_WRITE);
        act_o[10] = (id_i == `PSM_ID_LATCH_CLR);
        act_o[11] = (id_i == `PSM_ID_SEQ_HIST_CLR);
        act_o[12] = (id_i == `PSM_ID_TRIP_CLR);
        act_o[13] = (id_i == `PSM_ID_TORQUE_OFF_REL);
        act_o[14] = (id_i == `PSM_ID_ZERO_PRESET);
        act_o[15] = (id_i == `PSM_ID_ZERO_PRESET_CLR);
        act_o[16] = (id_i == `PSM_ID_INFO_CLR);
        act_o[17] = (id_i == `PSM_ID_INFO_HIST_CLR);
        is_maint_o = (|act_o) | (id_i == `PSM_ID_HIST_SEL);
    end
endmodule
`default_nettype wire

/* File: hdl/psm_param_store.sv */
// parameter store with update classes and maintenance command execution
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"
// How it works
// - every parameter is held, copied and applied as a 32-bit word
// - parameter writes land in working ram only, never in nv storage
// - after reset the whole nv image copies into ram, then all apply
// - ram is cleared by reset; nv image lives in its own array
// - id 201 copies every ram word into nv storage
// - class a writes apply at once
// - class b writes apply once motion has stopped
// - class c writes apply at configure or power cycle
// - class d writes apply only at power cycle
// - id 192 resets present alarm, id 194 erases alarm history
// - id 213 selects history entry 0..10, reset value 0
// - id 200 reloads nv into ram; 203 and 204 read and write backup
// - id 199 defaults all but comm words; id 202 defaults everything
// - id 198 applies pending class c values
// - id 197 presets position, 209 zero preset, 210 clears it
// - ids 205 to 212 pulse their clear, release and preset actions
// - write-end rises when done and falls after request drops
module psm_param_store
#(
    parameter int N_PARAM = 16,
    parameter int N_COMM  = 2,
    parameter logic [31:0] DEFAULT_WORD = `PSM_WORD_RST
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_req_i,
    input  wire logic [15:0] wr_id_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic [2*N_PARAM-1:0] class_map_i,
    input  wire logic        motion_busy_i,
    input  wire logic [$clog2(N_PARAM)-1:0] rd_idx_i,
    output logic             wr_end_o,
    output logic             busy_o,
    output logic [31:0]      rd_ram_o,
    output logic [31:0]      rd_active_o,
    output logic [31:0]      hist_sel_o,
    output logic             alarm_reset_o,
    output logic             alarm_hist_clr_o,
    output logic             pos_preset_o,
    output logic             encoder_zero_preset_o,
    output logic             encoder_zero_preset_clr_o,
    output logic             latch_clr_o,
    output logic             seq_hist_clr_o,
    output logic             trip_clr_o,
    output logic             torque_off_release_o,
    output logic             info_clr_o,
    output logic             info_hist_clr_o,
    output logic             param_applied_o
);
    // index width of the parameter arrays
    localparam int IW = $clog2(N_PARAM);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    // one packed record holds all control state, so reset and
    // next-state logic stay in one place each
    typedef struct packed {
        psm_pkg::psm_state_e st;
        psm_pkg::psm_copy_e  kind;
        logic [IW:0]         idx;
        logic                req_seen;
        logic [N_PARAM-1:0]  pend_b;
        logic [N_PARAM-1:0]  pend_c;
        logic [31:0]         hist_sel;
        logic [17:0]         act;
        logic                wr_end;
        logic                applied;
        logic                apply_all;
    } psm_state_s;

    psm_state_s s_q;
    psm_state_s s_d;

    // word arrays: working ram, active copy, nv image, backup image
    // nv and backup images carry no reset, as storage that keeps
    // its content while control power is off
    logic [31:0] ram_q    [N_PARAM];
    logic [31:0] active_q [N_PARAM];
    logic [31:0] nv_q     [N_PARAM];
    logic [31:0] bk_q     [N_PARAM];

    logic [17:0] act_dec;
    logic        is_maint;
    logic        req_new;
    logic        param_hit;
    logic [IW-1:0] wr_idx;
    logic [IW-1:0] cp_idx;
    psm_pkg::psm_class_e wr_cls;

    psm_cmd_decode u_dec
    (
        .id_i       (wr_id_i),
        .act_o      (act_dec),
        .is_maint_o (is_maint)
    );

    // --------------------------------------------------------------
    // request decode
    // --------------------------------------------------------------
    // a held request is taken once: req_seen blocks it until the
    // host has dropped it after write-end
    assign req_new   = wr_req_i & ~s_q.req_seen &
                       (s_q.st == psm_pkg::PSM_IDLE);
    assign wr_idx    = wr_id_i[IW-1:0];
    assign param_hit = ~is_maint && (wr_id_i < 16'(N_PARAM));
    assign wr_cls    = psm_pkg::psm_class_e'(class_map_i[2*wr_idx +: 2]);
    assign cp_idx    = s_q.idx[IW-1:0];

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        s_d           = s_q;
        // pulses and apply strobes last one cycle unless set again
        s_d.act       = '0;
        s_d.applied   = 1'b0;
        s_d.apply_all = 1'b0;
        case (s_q.st)
            psm_pkg::PSM_BOOT:
            begin
                s_d.st   = psm_pkg::PSM_COPY;
                s_d.kind = psm_pkg::PSM_COPY_NV_TO_RAM;
                s_d.idx  = '0;
            end
            psm_pkg::PSM_IDLE:
            begin
                if (req_new)
                begin
                    s_d.req_seen = 1'b1;
                    s_d.st       = psm_pkg::PSM_WAIT_DROP;
                    s_d.wr_end   = 1'b1;
                    if (act_dec[5] | act_dec[6] | act_dec[8] |
                        act_dec[9] | act_dec[4] | act_dec[7])
                    begin
                        s_d.st     = psm_pkg::PSM_COPY;
                        s_d.wr_end = 1'b0;
                        s_d.idx    = '0;
                        if (act_dec[5])
                            s_d.kind = psm_pkg::PSM_COPY_NV_TO_RAM;
                        else if (act_dec[6])
                            s_d.kind = psm_pkg::PSM_COPY_RAM_TO_NV;
                        else if (act_dec[8])
                            s_d.kind = psm_pkg::PSM_COPY_BK_TO_RAM;
                        else if (act_dec[9])
                            s_d.kind = psm_pkg::PSM_COPY_RAM_TO_BK;
                        else if (act_dec[4])
                            s_d.kind = psm_pkg::PSM_COPY_INIT_KEEP;
                        else
                            s_d.kind = psm_pkg::PSM_COPY_INIT_ALL;
                    end
                    else
                    begin
                        s_d.act = act_dec;
                        if (act_dec[3])
                        begin
                            s_d.pend_c  = '0;
                            s_d.applied = 1'b1;
                        end
                        if (wr_id_i == `PSM_ID_HIST_SEL &&
                            wr_data_i <= `PSM_HIST_SEL_MAX)
                            s_d.hist_sel = wr_data_i;
                        if (param_hit)
                        begin
                            case (wr_cls)
                                psm_pkg::PSM_CLASS_A:
                                    s_d.applied = 1'b1;
                                psm_pkg::PSM_CLASS_B:
                                    s_d.pend_b[wr_idx] = 1'b1;
                                psm_pkg::PSM_CLASS_C:
                                    s_d.pend_c[wr_idx] = 1'b1;
                                default:
                                    s_d.applied = 1'b0;
                            endcase
                        end
                    end
                end
                else if (!wr_req_i)
                    s_d.req_seen = 1'b0;
                // class b words wait for motion to stop; a class b
                // write taken in the same cycle keeps its own mark
                if (!motion_busy_i && |s_q.pend_b)
                begin
                    s_d.pend_b  = '0;
                    s_d.applied = 1'b1;
                    if (req_new && param_hit &&
                        wr_cls == psm_pkg::PSM_CLASS_B)
                        s_d.pend_b[wr_idx] = 1'b1;         // new write still waits
                end
            end
            psm_pkg::PSM_COPY:
            begin
                s_d.idx = s_q.idx + 1'b1;
                if (s_q.idx == (IW+1)'(N_PARAM - 1))
                begin
                    // a command copy ends in the handshake, the boot
                    // copy ends in a full apply
                    if (s_q.req_seen)
                    begin
                        s_d.st     = psm_pkg::PSM_WAIT_DROP;
                        s_d.wr_end = 1'b1;
                    end
                    else
                        s_d.st = psm_pkg::PSM_IDLE;
                    if (s_q.kind != psm_pkg::PSM_COPY_RAM_TO_NV &&
                        s_q.kind != psm_pkg::PSM_COPY_RAM_TO_BK)
                    begin
                        if (!s_q.req_seen)
                            s_d.apply_all = 1'b1;
                        s_d.pend_b = '0;
                        s_d.pend_c = '0;
                        s_d.applied = 1'b1;
                    end
                end
            end
            psm_pkg::PSM_WAIT_DROP:
            begin
                if (!wr_req_i)
                begin
                    s_d.wr_end   = 1'b0;
                    s_d.req_seen = 1'b0;
                    s_d.st       = psm_pkg::PSM_IDLE;
                end
            end
            default:
                s_d.st = psm_pkg::PSM_BOOT;
        endcase
    end

    // --------------------------------------------------------------
    // state register; reset stands for control power-on
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q          <= '0;
            s_q.st       <= psm_pkg::PSM_BOOT;
            s_q.hist_sel <= `PSM_HIST_SEL_RST;
        end
        else
            s_q <= s_d;
    end

    // --------------------------------------------------------------
    // word arrays, one lane per parameter
    // --------------------------------------------------------------
    for (genvar g = 0; g < N_PARAM; g++)
    begin : g_word
        logic copy_hit;
        logic write_hit;
        logic is_comm;
        assign copy_hit  = (s_q.st == psm_pkg::PSM_COPY) &&
                           (cp_idx == IW'(g));
        assign write_hit = req_new && param_hit && (wr_idx == IW'(g));
        assign is_comm   = (g >= N_PARAM - N_COMM);

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                ram_q[g]    <= `PSM_WORD_RST;
                active_q[g] <= `PSM_WORD_RST;
            end
            else
            begin
                if (copy_hit)
                begin
                    case (s_q.kind)
                        psm_pkg::PSM_COPY_NV_TO_RAM:
                            ram_q[g] <= nv_q[g];
                        psm_pkg::PSM_COPY_BK_TO_RAM:
                            ram_q[g] <= bk_q[g];
                        psm_pkg::PSM_COPY_INIT_KEEP:
                            if (!is_comm)
                                ram_q[g] <= DEFAULT_WORD;
                        psm_pkg::PSM_COPY_INIT_ALL:
                            ram_q[g] <= DEFAULT_WORD;
                        default:
                            ram_q[g] <= ram_q[g];
                    endcase
                end
                else if (write_hit)
                    ram_q[g] <= wr_data_i;
                if (s_q.apply_all ||
                    (s_q.applied && !s_q.pend_b[g] && !s_q.pend_c[g] &&
                     class_map_i[2*g +: 2] != 2'h3))
                    active_q[g] <= ram_q[g];
            end
        end

        // nv and backup images survive the reset
        always_ff @(posedge clk_i)
        begin
            if (copy_hit && s_q.kind == psm_pkg::PSM_COPY_RAM_TO_NV)
                nv_q[g] <= ram_q[g];
            if (copy_hit && s_q.kind == psm_pkg::PSM_COPY_RAM_TO_BK)
                bk_q[g] <= ram_q[g];
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_ram_o    <= `PSM_WORD_RST;
            rd_active_o <= `PSM_WORD_RST;
        end
        else
        begin
            rd_ram_o    <= ram_q[rd_idx_i];
            rd_active_o <= active_q[rd_idx_i];
        end
    end

    assign wr_end_o                  = s_q.wr_end;
    assign busy_o                    = (s_q.st == psm_pkg::PSM_COPY) |
                                       (s_q.st == psm_pkg::PSM_BOOT);
    assign hist_sel_o                = s_q.hist_sel;
    assign alarm_reset_o             = s_q.act[0];
    assign alarm_hist_clr_o          = s_q.act[1];
    assign pos_preset_o              = s_q.act[2];
    assign latch_clr_o               = s_q.act[10];
    assign seq_hist_clr_o            = s_q.act[11];
    assign trip_clr_o                = s_q.act[12];
    assign torque_off_release_o      = s_q.act[13];
    assign encoder_zero_preset_o     = s_q.act[14];
    assign encoder_zero_preset_clr_o = s_q.act[15];
    assign info_clr_o                = s_q.act[16];
    assign info_hist_clr_o           = s_q.act[17];
    assign param_applied_o           = s_q.applied | s_q.apply_all;
endmodule
`default_nettype wire

/* File: verif/psm_host_model.sv */
// host model issuing parameter writes with the write-end handshake
`timescale 1ns/1ps
`default_nettype none
module psm_host_model
(
    input  wire logic        clk_i,
    input  wire logic        wr_end_i,
    output logic             wr_req_o,
    output logic [15:0]      wr_id_o,
    output logic [31:0]      wr_data_o,
    output logic             fail_o
);
    // idle lines start away from any real id
    initial
    begin
        wr_req_o  = 1'b0;
        wr_id_o   = 16'hffff;
        wr_data_o = 32'hffffffff;
        fail_o    = 1'b0;
    end

    // one whole 32-bit write, held until write-end is sampled high
    task automatic write(input logic [15:0] id, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        #1;
        wr_req_o  = 1'b1;
        wr_id_o   = id;
        wr_data_o = d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wr_end_i !== 1'b1 && n < 300);
        if (n >= 300)
            fail_o = 1'b1;
        #1;
        wr_req_o  = 1'b0;
        wr_id_o   = ~id; // released lines lose the last value
        wr_data_o = ~d;
        n = 0;
        // next write waits for write-end low plus an idle cycle
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wr_end_i !== 1'b0 && n < 300);
        if (n >= 300)
            fail_o = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: verif/psm_param_store_monitor.sv */
// assertions watching the parameter store ports
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"
module psm_param_store_monitor
#(
    parameter int N_PARAM = 16
)
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wr_req_i,
    input wire logic [15:0] wr_id_i,
    input wire logic        wr_end_o,
    input wire logic        busy_o,
    input wire logic [31:0] hist_sel_o,
    input wire logic        alarm_reset_o,
    input wire logic        alarm_hist_clr_o,
    input wire logic        pos_preset_o,
    input wire logic        encoder_zero_preset_o,
    input wire logic        torque_off_release_o,
    input wire logic        info_clr_o,
    input wire logic        info_hist_clr_o,
    input wire logic        param_applied_o
);
    localparam int BOOT_MAX = N_PARAM + 4;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // boot, handshake, selector and pulse checks
    // ----------------------------------------------------------------
    property p_boot; $fell(rst_i) |-> ##[0:BOOT_MAX] !busy_o; endproperty
    a_boot: assert property (p_boot) else $error("boot copy hung");
    property p_hold; wr_end_o && wr_req_i |=> wr_end_o; endproperty
    a_hold: assert property (p_hold) else $error("write-end fell early");
    property p_drop; wr_end_o && !wr_req_i |=> !wr_end_o; endproperty
    a_drop: assert property (p_drop) else $error("write-end stuck");
    property p_cause; $rose(wr_end_o) |-> $past(wr_req_i); endproperty
    a_cause: assert property (p_cause) else $error("write-end no req");
    property p_sel; hist_sel_o <= `PSM_HIST_SEL_MAX; endproperty
    a_sel: assert property (p_sel) else $error("selector range");
    property p_sel_rst; $fell(rst_i) |-> hist_sel_o == 32'h0; endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("selector reset");
    property p_alarm;
        alarm_reset_o |-> $past(wr_id_i) == `PSM_ID_ALARM_RESET
            ##1 !alarm_reset_o;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm pulse");
    property p_ahist; alarm_hist_clr_o |-> $past(wr_id_i) == 16'h00c2;
    endproperty
    a_ahist: assert property (p_ahist) else $error("history clear");
    property p_pre; pos_preset_o |-> $past(wr_id_i) == 16'h00c5; endproperty
    a_pre: assert property (p_pre) else $error("position preset");
    property p_zero;
        encoder_zero_preset_o |-> $past(wr_id_i) == 16'h00d1;
    endproperty
    a_zero: assert property (p_zero) else $error("zero preset");
    property p_torq;
        torque_off_release_o |-> $past(wr_id_i) == 16'h00d0;
    endproperty
    a_torq: assert property (p_torq) else $error("torque release");
    property p_info; info_clr_o |-> $past(wr_id_i) == 16'h00d3; endproperty
    a_info: assert property (p_info) else $error("info clear");
    property p_ihist;
        info_hist_clr_o |-> $past(wr_id_i) == 16'h00d4;
    endproperty
    a_ihist: assert property (p_ihist) else $error("info history");
    c_boot: cover property ($fell(busy_o));
    c_alarm: cover property (alarm_reset_o);
    c_apply: cover property (param_applied_o);
endmodule
bind psm_param_store psm_param_store_monitor #(.N_PARAM(N_PARAM)) u_mon
(
    .clk_i(clk_i), .rst_i(rst_i), .wr_req_i(wr_req_i), .wr_id_i(wr_id_i),
    .wr_end_o(wr_end_o), .busy_o(busy_o), .hist_sel_o(hist_sel_o),
    .alarm_reset_o(alarm_reset_o), .alarm_hist_clr_o(alarm_hist_clr_o),
    .pos_preset_o(pos_preset_o),
    .encoder_zero_preset_o(encoder_zero_preset_o),
    .torque_off_release_o(torque_off_release_o), .info_clr_o(info_clr_o),
    .info_hist_clr_o(info_hist_clr_o), .param_applied_o(param_applied_o)
);
`default_nettype wire

/* File: verif/parameter_store_maintenance_cmds_test.sv */
// self-checking bench of the parameter store and maintenance commands
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module parameter_store_maintenance_cmds_test;
    localparam logic [31:0] V0 = 32'h8421f00d;
    localparam logic [31:0] V0B = 32'h13579bdf;
    localparam logic [31:0] V1 = 32'hc001d00d;
    localparam logic [31:0] V2 = 32'h2468ace0;
    localparam logic [31:0] V3 = 32'hfedcba98;
    localparam logic [15:0] PID [11] = '{16'h00c0, 16'h00c2, 16'h00c5,
        16'h00d1, 16'h00d2, 16'h00cd, 16'h00ce, 16'h00cf, 16'h00d0,
        16'h00d3, 16'h00d4};
    logic        clk_i, rst_i, motion, clr, host_fail, wr_req, wr_end, busy;
    logic [15:0] wr_id;
    logic [31:0] wr_data, rd_ram, rd_act, hist_sel, r, a;
    logic [7:0]  class_map;
    logic [1:0]  rd_idx;
    logic [11:0] seen;
    wire  [11:0] pv;
    int          checks, bad_count, cyc, hits;

    psm_param_store #(.N_PARAM(4), .N_COMM(1)) dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wr_req_i(wr_req), .wr_id_i(wr_id),
        .wr_data_i(wr_data), .class_map_i(class_map), .motion_busy_i(motion),
        .rd_idx_i(rd_idx), .wr_end_o(wr_end), .busy_o(busy),
        .rd_ram_o(rd_ram), .rd_active_o(rd_act), .hist_sel_o(hist_sel),
        .alarm_reset_o(pv[10]), .alarm_hist_clr_o(pv[9]),
        .pos_preset_o(pv[8]), .encoder_zero_preset_o(pv[7]),
        .encoder_zero_preset_clr_o(pv[6]), .latch_clr_o(pv[5]),
        .seq_hist_clr_o(pv[4]), .trip_clr_o(pv[3]),
        .torque_off_release_o(pv[2]), .info_clr_o(pv[1]),
        .info_hist_clr_o(pv[0]), .param_applied_o(pv[11])
    );
    psm_host_model u_host
    (
        .clk_i(clk_i), .wr_end_i(wr_end), .wr_req_o(wr_req),
        .wr_id_o(wr_id), .wr_data_o(wr_data), .fail_o(host_fail)
    );

    // 50 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // sticky record of pulses since the last arm
    always @(posedge clk_i)
    begin
        seen <= clr ? 12'h0 : seen | pv;
        hits <= clr ? 0 : hits + $countones(pv[10:0]);
    end

    // hang guard
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [15:0] id, input logic [31:0] d);
        u_host.write(id, d);
    endtask
    task automatic rd(input logic [1:0] i);
        @(posedge clk_i);
        #1 rd_idx = i;
        repeat (2) @(posedge clk_i);
        #1;
        r = rd_ram;
        a = rd_act;
    endtask
    task automatic arm();
        clr = 1'b1;
        @(posedge clk_i);
        #1 clr = 1'b0;
    endtask
    task automatic do_reset();
        int n;
        #1 rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 rst_i = 1'b0;
        n = 0;
        repeat (2) @(posedge clk_i);
        while (busy !== 1'b0 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        #1;
        `CHK(busy, 1'b0)
        `CHK(hist_sel, `PSM_HIST_SEL_RST)
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_baseline();
        wr(`PSM_ID_INIT_ALL, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            rd(2'(i));
            `CHK(r, `PSM_WORD_RST)
        end
        wr(`PSM_ID_NV_WRITE, 32'h0);
        do_reset();
        for (int i = 0; i < 4; i++)
        begin
            rd(2'(i));
            `CHK(a, `PSM_WORD_RST)
        end
    endtask
    task automatic t_class_ab();
        arm();
        wr(16'h0000, V0);
        rd(0);
        `CHK(a, V0)
        `CHK(seen[11], 1'b1)
        motion = 1'b1;
        wr(16'h0001, V1);
        rd(1);
        `CHK(r, V1)
        `CHK(a, 32'h0)
        motion = 1'b0;
        repeat (4) @(posedge clk_i);
        rd(1);
        `CHK(a, V1)
    endtask
    task automatic t_class_cd();
        wr(16'h0002, V2);
        wr(16'h0003, V3);
        rd(2);
        `CHK(a, 32'h0)
        wr(`PSM_ID_CONFIGURE, 32'h0);
        rd(2);
        `CHK(a, V2)
        wr(16'h0000, V0B);
        rd(2);
        `CHK(a, V2)
        rd(3);
        `CHK(a, 32'h0)
        wr(`PSM_ID_NV_WRITE, 32'h0);
        do_reset();
        rd(3);
        `CHK(a, V3)
        rd(1);
        `CHK(r, V1)
    endtask
    task automatic t_nv_backup_init();
        wr(16'h0000, 32'h1);
        wr(`PSM_ID_NV_READ, 32'h0);
        rd(0);
        `CHK(r, V0B)
        wr(`PSM_ID_BACKUP_WRITE, 32'h0);
        wr(16'h0001, 32'h2);
        wr(`PSM_ID_BACKUP_READ, 32'h0);
        rd(1);
        `CHK(r, V1)
        wr(`PSM_ID_INIT_KEEP_COMM, 32'h0);
        rd(0);
        `CHK(r, `PSM_WORD_RST)
        rd(3);
        `CHK(r, V3)
    endtask
    task automatic t_pulses();
        for (int k = 0; k < 11; k++)
        begin
            arm();
            wr(PID[k], {16'ha5c3, PID[k]});
            repeat (2) @(posedge clk_i);
            #1;
            `CHK(seen, 12'h400 >> k)
            `CHK(hits, 1)
        end
    endtask
    task automatic t_hist_sel();
        wr(`PSM_ID_HIST_SEL, 32'h0000000a);
        `CHK(hist_sel, 32'h0000000a)
        wr(`PSM_ID_HIST_SEL, 32'h0000000b);
        `CHK(hist_sel, 32'h0000000a)
        wr(`PSM_ID_HIST_SEL, 32'h00000001);
        `CHK(hist_sel, 32'h00000001)
    endtask
    task automatic t_volatile();
        wr(16'h0002, 32'hdead0002);
        do_reset();
        rd(2);
        `CHK(r, V2)
    endtask

    // main sequence
    initial
    begin
        rst_i = 1'b1;
        motion = 1'b0;
        clr = 1'b1;
        rd_idx = 2'h0;
        class_map = 8'he4;
        checks = 0;
        bad_count = 0;
        cyc = 0;
        do_reset();
        t_baseline();
        t_class_ab();
        t_class_cd();
        t_nv_backup_init();
        t_pulses();
        t_hist_sel();
        t_volatile();
        `CHK(host_fail, 1'b0)
        summarize();
    end
endmodule
`default_nettype wire
